// File: verilog/timer_channel.sv
`timescale 1ns/10ps
module timer_channel #(
    parameter int unsigned CNT_W  = timer_channel_pkg::CNT_W,
    parameter int unsigned ADDR_W = timer_channel_pkg::APB_ADDR_W
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    output logic     [31:0]       prdata,
    output logic                  pready,
    output logic                  pslverr,
    input wire logic              chan_pin_in,
    output logic                  chan_pin_out,
    output logic                  chan_pin_oe,
    output logic                  chan_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    // all channel state in one struct: one comb fill, one flop stage
    typedef struct packed {
        logic             flag;      // channel_event_flag
        logic             irq_en;    // channel_irq_enable
        logic             ms_high;   // mode_select_high
        logic             ms_low;    // mode_select_low
        logic [1:0]       els;       // edge_level_select high:low
        logic             armed;     // flag was read as one, clear may follow
        logic [CNT_W-1:0] value;     // channel value
        logic [CNT_W-1:0] modulo;    // counter modulo
        logic             center;    // center_pwm_select
        logic             cnt_en;    // counter runs
        logic             pin_out;   // pin level
        logic             pin_oe;    // pin driven
        logic             irq;       // interrupt request
        logic [31:0]      rdata;     // apb read data
        logic             ready;     // apb ready
        logic             slverr;    // apb error
    } chan_state_t;

    // reset image, all constants
    // no signal feeds the reset branch, so the async reset stays clean
    localparam chan_state_t RESET_STATE = '{
        flag:    timer_channel_pkg::CSC_RESET[timer_channel_pkg::FLAG_POS],
        irq_en:  timer_channel_pkg::CSC_RESET[timer_channel_pkg::IE_POS],
        ms_high: timer_channel_pkg::CSC_RESET[timer_channel_pkg::MSH_POS],
        ms_low:  timer_channel_pkg::CSC_RESET[timer_channel_pkg::MSL_POS],
        els:     timer_channel_pkg::CSC_RESET[timer_channel_pkg::ELSH_POS:timer_channel_pkg::ELSL_POS],
        armed:   1'b0,
        value:   CNT_W'(timer_channel_pkg::VALUE_RESET),
        modulo:  CNT_W'(timer_channel_pkg::MOD_RESET),
        center:  timer_channel_pkg::TCTRL_RESET[timer_channel_pkg::CPWM_POS],
        cnt_en:  timer_channel_pkg::TCTRL_RESET[timer_channel_pkg::CNTEN_POS],
        pin_out: 1'b0,
        pin_oe:  1'b0,
        irq:     1'b0,
        rdata:   32'h0000_0000,
        ready:   1'b0,
        slverr:  1'b0
    };

    chan_state_t st_r;                    // registered state
    chan_state_t st_nxt;                  // next state

    timer_channel_pkg::chan_mode_t mode;  // decoded channel mode
    logic             cap_rise;           // synchronised rising edge
    logic             cap_fall;           // synchronised falling edge
    logic             cap_edge;           // selected active edge
    logic             tick;               // counter advances this cycle
    logic             match;              // counter equals channel value
    logic             duty_extreme;       // pwm at 0% or 100%
    logic             event_hit;          // channel event this cycle
    logic             wr_access;          // apb write completes
    logic             rd_access;          // apb read completes
    logic [CNT_W-1:0] count_top;          // counter top value
    logic [7:0]       csc_word;           // channel_status_control image

    // counter control out, count and direction back
    counter_if #(.W(CNT_W)) cnt_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte address decode for the error answer; the read mux uses addr_is
    // only the low byte decodes, so a wider bus sees the map alias
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] a8;
        a8 = 8'(a);
        return (a8 == timer_channel_pkg::CSC_OFFSET)   || (a8 == timer_channel_pkg::VALUE_OFFSET) ||
               (a8 == timer_channel_pkg::TCTRL_OFFSET) || (a8 == timer_channel_pkg::MOD_OFFSET)   ||
               (a8 == timer_channel_pkg::COUNT_OFFSET);
    endfunction : addr_mapped

    // is the access aimed at one register
    // used by every write strobe and by the read mux
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return (8'(a) == off);
    endfunction : addr_is

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    // pin input, synchronised before any edge logic
    // costs two cycles: a capture trails its pin edge by that much
    pin_sync u_pin_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .pin_async (chan_pin_in),
        .rise      (cap_rise),
        .fall      (cap_fall)
    );

    // main counter, private to this channel
    // a software clear wins over counting in the same cycle
    main_counter #(.W(CNT_W)) u_main_counter (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .bus     (cnt_bus.cnt)
    );

    // modulo of zero lets the counter run over its full range
    // the counter serves this channel only, so center mode sets its count direction
    assign count_top      = (st_r.modulo == '0) ? '1 : st_r.modulo;
    assign cnt_bus.enable = st_r.cnt_en;
    assign cnt_bus.center = st_r.center;
    assign cnt_bus.top    = count_top;
    assign cnt_bus.clear  = wr_access && addr_is(paddr, timer_channel_pkg::COUNT_OFFSET);

    ////////////////////////////////////////////////////////////////////////////////
    // event detection

    always_comb begin
        mode = timer_channel_pkg::decode_mode(st_r.center, st_r.ms_high, st_r.ms_low);
        tick = st_r.cnt_en;
        // compare only on a live count so a stopped counter fires no match event
        match        = tick && (cnt_bus.count == st_r.value);
        // above the top never matches (always on); zero matches at the wrap
        // and wins there (always off): neither is a real pwm edge
        duty_extreme = (st_r.value == '0) || (st_r.value > count_top);
        case (st_r.els)
            timer_channel_pkg::ELS_LOW:  cap_edge = cap_rise;
            timer_channel_pkg::ELS_HIGH: cap_edge = cap_fall;
            timer_channel_pkg::ELS_BOTH: cap_edge = cap_rise | cap_fall;
            default:                     cap_edge = 1'b0;
        endcase
        case (mode)
            // a pin still moving at mode entry can look like an edge
            timer_channel_pkg::MODE_CAPTURE: event_hit = cap_edge;
            timer_channel_pkg::MODE_COMPARE: event_hit = match;
            timer_channel_pkg::MODE_EPWM:    event_hit = match && !duty_extreme;
            timer_channel_pkg::MODE_CPWM:    event_hit = match && !duty_extreme;
            default:                         event_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb qualifiers: one access cycle, ready comes from the setup cycle
    // an answer with pslverr leaves every register untouched

    assign wr_access = psel && penable && st_r.ready && pwrite && !st_r.slverr;
    assign rd_access = psel && penable && st_r.ready && !pwrite && !st_r.slverr;
    assign csc_word  = {st_r.flag, st_r.irq_en, st_r.ms_high, st_r.ms_low, st_r.els, 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // setup cycle samples read data so the access cycle can finish at once
        // trade-off: read data is a cycle old, so arming uses the sampled word
        st_nxt.ready  = psel && !penable;
        st_nxt.slverr = psel && !penable && !addr_mapped(paddr);
        st_nxt.rdata  = 32'h0000_0000;
        if (psel && !penable) begin
            if (addr_is(paddr, timer_channel_pkg::CSC_OFFSET)) begin
                st_nxt.rdata = 32'(csc_word);
            end else if (addr_is(paddr, timer_channel_pkg::VALUE_OFFSET)) begin
                st_nxt.rdata = 32'(st_r.value);
            end else if (addr_is(paddr, timer_channel_pkg::TCTRL_OFFSET)) begin
                st_nxt.rdata = 32'({6'h00, st_r.center, st_r.cnt_en});
            end else if (addr_is(paddr, timer_channel_pkg::MOD_OFFSET)) begin
                st_nxt.rdata = 32'(st_r.modulo);
            end else if (addr_is(paddr, timer_channel_pkg::COUNT_OFFSET)) begin
                st_nxt.rdata = 32'(cnt_bus.count);
            end
        end

        // a read that saw the flag clear leaves the sequence idle
        // a read that returned the flag set arms the clear
        if (rd_access && addr_is(paddr, timer_channel_pkg::CSC_OFFSET) && st_r.rdata[timer_channel_pkg::FLAG_POS]) begin
            st_nxt.armed = 1'b1;
        end

        // register writes
        // csc fields land together; the flag bit only ever clears here
        if (wr_access && addr_is(paddr, timer_channel_pkg::CSC_OFFSET)) begin
            st_nxt.irq_en  = pwdata[timer_channel_pkg::IE_POS];
            st_nxt.ms_high = pwdata[timer_channel_pkg::MSH_POS];
            st_nxt.ms_low  = pwdata[timer_channel_pkg::MSL_POS];
            st_nxt.els     = pwdata[timer_channel_pkg::ELSH_POS:timer_channel_pkg::ELSL_POS];
            // zero write after armed read clears
            // a one written here does nothing
            if (st_r.armed && !pwdata[timer_channel_pkg::FLAG_POS]) begin
                st_nxt.flag = 1'b0;
            end
            // any write ends the sequence either way
            st_nxt.armed = 1'b0;
        end
        // capture mode owns the value register, software writes are dropped
        if (wr_access && addr_is(paddr, timer_channel_pkg::VALUE_OFFSET) &&
            (mode != timer_channel_pkg::MODE_CAPTURE)) begin
            st_nxt.value = pwdata[CNT_W-1:0];
        end
        if (wr_access && addr_is(paddr, timer_channel_pkg::TCTRL_OFFSET)) begin
            st_nxt.center = pwdata[timer_channel_pkg::CPWM_POS];
            st_nxt.cnt_en = pwdata[timer_channel_pkg::CNTEN_POS];
        end
        if (wr_access && addr_is(paddr, timer_channel_pkg::MOD_OFFSET)) begin
            st_nxt.modulo = pwdata[CNT_W-1:0];
        end

        // events: the set wins over a clear in the same cycle
        // so an event landing on the clearing write is never lost
        if (event_hit) begin
            st_nxt.flag  = 1'b1;
            // a fresh event restarts the clear
            st_nxt.armed = 1'b0;
        end

        // only the capture path writes the value in this mode
        // capture copies the count
        if (event_hit && (mode == timer_channel_pkg::MODE_CAPTURE)) begin
            st_nxt.value = cnt_bus.count;
        end

        // pin behaviour per mode
        case (mode)
            timer_channel_pkg::MODE_COMPARE: begin
                if (match) begin
                    case (st_r.els)
                        timer_channel_pkg::ELS_LOW:  st_nxt.pin_out = ~st_r.pin_out;
                        timer_channel_pkg::ELS_HIGH: st_nxt.pin_out = 1'b0;
                        timer_channel_pkg::ELS_BOTH: st_nxt.pin_out = 1'b1;
                        default:                     st_nxt.pin_out = st_r.pin_out;
                    endcase
                end
            end
            timer_channel_pkg::MODE_EPWM: begin
                // wrap opens the pulse, the match ends it; on a tie the match wins
                // active at wrap, inactive on match
                if (tick && (cnt_bus.count == '0)) begin
                    st_nxt.pin_out = ~st_r.els[0];
                end
                if (match) begin
                    st_nxt.pin_out = st_r.els[0];
                end
            end
            timer_channel_pkg::MODE_CPWM: begin
                // a match at the top turn still counts as counting up
                // polarity on the up-count match
                if (match && cnt_bus.counting_up) begin
                    st_nxt.pin_out = st_r.els[0];
                end else if (match) begin
                    st_nxt.pin_out = ~st_r.els[0];
                end
            end
            default: begin
                // capture leaves the output latch alone
                st_nxt.pin_out = st_r.pin_out;
            end
        endcase

        // capture only listens, so it keeps the pin released as well
        // select 00 releases the pin, capture never drives it
        st_nxt.pin_oe = (st_nxt.els != timer_channel_pkg::ELS_NONE) &&
                        (timer_channel_pkg::decode_mode(st_nxt.center, st_nxt.ms_high, st_nxt.ms_low)
                         != timer_channel_pkg::MODE_CAPTURE);

        // next-state flag keeps the request on the flag's own edge
        // request follows flag and enable
        st_nxt.irq = st_nxt.flag && st_nxt.irq_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register, frozen while clk_en is low
    // a low clk_en stalls apb too: pready waits with everything else

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= RESET_STATE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    // no output passes through logic after its flop

    assign prdata       = st_r.rdata;
    assign pready       = st_r.ready;
    assign pslverr      = st_r.slverr;
    assign chan_pin_out = st_r.pin_out;
    assign chan_pin_oe  = st_r.pin_oe;
    assign chan_irq     = st_r.irq;

endmodule : timer_channel

// File: verilog/timer_channel_pkg.sv
package timer_channel_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned APB_ADDR_W = 8;              // apb byte address width
    localparam int unsigned CNT_W      = 16;             // main counter and channel value width

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets, one aligned word each
    localparam logic [7:0] CSC_OFFSET   = 8'h00;         // channel_status_control
    localparam logic [7:0] VALUE_OFFSET = 8'h04;         // channel value
    localparam logic [7:0] TCTRL_OFFSET = 8'h08;         // timer control (center pwm, run)
    localparam logic [7:0] MOD_OFFSET   = 8'h0C;         // counter modulo
    localparam logic [7:0] COUNT_OFFSET = 8'h10;         // counter, write clears

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned FLAG_POS  = 7;               // channel_event_flag
    localparam int unsigned IE_POS    = 6;               // channel_irq_enable
    localparam int unsigned MSH_POS   = 5;               // mode_select_high
    localparam int unsigned MSL_POS   = 4;               // mode_select_low
    localparam int unsigned ELSH_POS  = 3;               // edge_level_select_high
    localparam int unsigned ELSL_POS  = 2;               // edge_level_select_low
    localparam int unsigned CPWM_POS  = 1;               // center_pwm_select
    localparam int unsigned CNTEN_POS = 0;               // counter run enable

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  CSC_RESET   = 8'h00;         // flag and all controls clear
    localparam logic [7:0]  TCTRL_RESET = 8'h00;         // up counting, stopped
    localparam logic [15:0] VALUE_RESET = 16'h0000;      // channel value
    localparam logic [15:0] MOD_RESET   = 16'h0000;      // zero means free running
    localparam logic [15:0] COUNT_RESET = 16'h0000;      // counter

    ////////////////////////////////////////////////////////////////////////////////
    // edge/level select codes
    localparam logic [1:0] ELS_NONE = 2'h0;              // pin released
    localparam logic [1:0] ELS_LOW  = 2'h1;              // rising / toggle
    localparam logic [1:0] ELS_HIGH = 2'h2;              // falling / clear
    localparam logic [1:0] ELS_BOTH = 2'h3;              // both edges / set

    // channel operating modes, one-hot
    typedef enum logic [3:0] {
        MODE_CAPTURE = 4'h1,
        MODE_COMPARE = 4'h2,
        MODE_EPWM    = 4'h4,
        MODE_CPWM    = 4'h8
    } chan_mode_t;

    // mode from center select and the two mode select bits
    function automatic chan_mode_t decode_mode(input logic center, input logic msh, input logic msl);
        chan_mode_t m;
        m = MODE_CAPTURE;
        if (center) begin
            m = MODE_CPWM;
        end else if (msh) begin
            m = MODE_EPWM;
        end else if (msl) begin
            m = MODE_COMPARE;
        end
        return m;
    endfunction : decode_mode

endpackage : timer_channel_pkg

// File: verilog/counter_if.sv
`timescale 1ns/10ps
// control toward the main counter and its value back
interface counter_if #(parameter int unsigned W = timer_channel_pkg::CNT_W) ();
    logic         enable;       // count on this cycle
    logic         center;       // up/down counting
    logic         clear;        // one-cycle clear pulse
    logic [W-1:0] top;          // highest count
    logic [W-1:0] count;        // current count
    logic         counting_up;  // direction
    modport ctrl (output enable, center, clear, top, input count, counting_up);
    modport cnt  (input enable, center, clear, top, output count, counting_up);
endinterface : counter_if

// File: verilog/main_counter.sv
`timescale 1ns/10ps
module main_counter #(
    parameter int unsigned W = timer_channel_pkg::CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    counter_if.cnt   bus
);

    typedef struct packed {
        logic [W-1:0] count;  // counter value
        logic         up;     // counting up
    } cnt_state_t;

    cnt_state_t st_r;         // registered state
    cnt_state_t st_nxt;       // next state

    ////////////////////////////////////////////////////////////////////////////////
    // next count
    always_comb begin
        st_nxt = st_r;
        if (bus.clear) begin
            st_nxt.count = '0;
            st_nxt.up    = 1'b1;
        end else if (bus.enable && !bus.center) begin
            // plain up counting with wrap after top
            st_nxt.up    = 1'b1;
            st_nxt.count = (st_r.count >= bus.top) ? '0 : st_r.count + W'(1);
        end else if (bus.enable && st_r.up) begin
            if (st_r.count >= bus.top) begin
                // top of zero would stall the turn, so hold at zero
                st_nxt.up    = (bus.top == '0);
                st_nxt.count = (bus.top == '0) ? '0 : st_r.count - W'(1);
            end else begin
                st_nxt.count = st_r.count + W'(1);
            end
        end else if (bus.enable) begin
            if (st_r.count == '0) begin
                st_nxt.up    = 1'b1;
                st_nxt.count = (bus.top == '0) ? '0 : W'(1);
            end else begin
                st_nxt.count = st_r.count - W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register, frozen while clk_en is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{count: W'(timer_channel_pkg::COUNT_RESET), up: 1'b1};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign bus.count       = st_r.count;
    assign bus.counting_up = st_r.up;

endmodule : main_counter

// File: verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic pin_async,
    output logic     rise,
    output logic     fall
);

    typedef struct packed {
        logic meta;   // first stage, read only by the second
        logic sync;   // settled level
        logic last;   // previous settled level
    } sync_state_t;

    sync_state_t st_r;      // registered state
    sync_state_t st_nxt;    // next state

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage pin synchroniser
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = pin_async;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // edges only from settled stages
    assign rise = st_r.sync & ~st_r.last;
    assign fall = ~st_r.sync & st_r.last;

endmodule : pin_sync

// File: testbench/pin_model.sv
`timescale 1ns/10ps
// far-side source on the channel pin; moves only just after a clock edge
module pin_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic     pin
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pin <= 1'b0;
        else pin <= level;
    end
endmodule : pin_model

// File: testbench/timer_channel_checker.sv
`timescale 1ns/10ps
// watches apb answers, pin enable and irq at the top ports
module timer_channel_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        chan_pin_oe,
    input wire logic        chan_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic csc_wr = pready && pwrite && paddr == timer_channel_pkg::CSC_OFFSET; // csc write lands
    wire logic mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;                     // five word slots
    apb_ready_a: assert property (psel && !penable && clk_en |=> pready) else $error("no ready");
    ready_place_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("rdata not idle");
    err_decode_a: assert property (pready |-> pslverr == !mapped) else $error("bad decode");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
    irq_fall_a: assert property ($fell(chan_irq) |-> $past(csc_wr)) else $error("irq lost");
    oe_steady_a: assert property (!(pready && pwrite) [*2] |=> $stable(chan_pin_oe)) else $error("oe moved");
    cover property ($rose(chan_irq));
    cover property (pslverr);
    cover property ($rose(chan_pin_oe));
endmodule : timer_channel_checker

// File: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lvl = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic        pready, pslverr, chan_pin_out, chan_pin_oe, chan_irq, drv;
    wire logic   pin = chan_pin_oe ? chan_pin_out : drv; // resolved pin level
    int          failures = 0, check_count = 0, cycles = 0;
    always #5 pclk = ~pclk;
    timer_channel i_timer_channel (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_pin_in(pin), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq));
    pin_model i_pin_model (.pclk(pclk), .presetn(presetn), .level(lvl), .pin(drv));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready with no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wait_irq;
        for (int i = 0; i < 300 && chan_irq !== 1'b1; i++) @(posedge pclk);
    endtask : wait_irq
    // cycles with the pin output high over a window of n edges
    task automatic count_high(input int n, output logic [31:0] c);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (chan_pin_out === 1'b1) c = c + 1;
        end
    endtask : count_high
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(0, 8'h00, 0, rd); chk(rd, 32'h0);
        apb(1, 8'h14, 32'hFF, rd); apb(0, 8'h14, 0, rd); chk(rd, 32'h0);
    endtask : t_reset
    // toggle on match, then the read-then-write-zero clear
    task automatic t_compare;
        apb(1, 8'h00, 32'h54, rd); apb(1, 8'h04, 32'h5, rd); apb(1, 8'h08, 32'h1, rd);
        wait_irq(); apb(1, 8'h08, 32'h0, rd);
        chk(chan_irq, 1); chk(chan_pin_out, 1); chk(chan_pin_oe, 1);
        apb(1, 8'h00, 32'h54, rd); apb(0, 8'h00, 0, rd); chk(rd, 32'hD4);
        apb(1, 8'h00, 32'h54, rd); #1 chk(chan_irq, 0);
        apb(1, 8'h00, 32'hD4, rd); apb(0, 8'h00, 0, rd); chk(rd, 32'h54);
        apb(1, 8'h00, 32'h50, rd); repeat (3) @(posedge pclk); chk(chan_pin_oe, 0);
    endtask : t_compare
    // rising capture, then an event inside the clear sequence
    task automatic t_capture;
        apb(1, 8'h00, 32'h44, rd); apb(1, 8'h10, 0, rd); apb(1, 8'h08, 32'h1, rd);
        @(posedge pclk); lvl <= 1'b1;
        wait_irq(); chk(chan_irq, 1); chk(chan_pin_oe, 0);
        apb(0, 8'h04, 0, v); apb(0, 8'h10, 0, rd); chk(v != 0 && v < rd, 1);
        apb(0, 8'h00, 0, rd); chk(rd, 32'hC4);
        lvl <= 1'b0; repeat (3) @(posedge pclk); lvl <= 1'b1; repeat (8) @(posedge pclk);
        apb(1, 8'h00, 32'h44, rd); apb(0, 8'h00, 0, rd); chk(rd, 32'hC4);
    endtask : t_capture
    // edge pwm (top 9, value 3), extreme duty, then center pwm
    task automatic t_pwm;
        apb(1, 8'h08, 0, rd); apb(1, 8'h00, 32'h38, rd); apb(1, 8'h0C, 32'h9, rd);
        apb(1, 8'h04, 32'h3, rd); apb(1, 8'h10, 0, rd); apb(0, 8'h00, 0, rd); chk(rd, 32'h38);
        apb(1, 8'h08, 32'h1, rd); repeat (20) @(posedge pclk);
        count_high(40, v); chk(v, 12);
        apb(0, 8'h00, 0, rd); chk(rd, 32'hB8);
        apb(1, 8'h04, 0, rd); repeat (12) @(posedge pclk); apb(0, 8'h00, 0, rd); apb(1, 8'h00, 32'h38, rd);
        repeat (24) @(posedge pclk); apb(0, 8'h00, 0, rd); chk(rd, 32'h38);
        count_high(20, v); chk(v, 0);
        apb(1, 8'h04, 32'h3, rd); apb(1, 8'h08, 32'h3, rd); repeat (40) @(posedge pclk);
        count_high(36, v); chk(v, 12);
    endtask : t_pwm
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_compare();
        t_capture();
        t_pwm();
        close_out();
    end
endmodule : tb_top
bind timer_channel timer_channel_checker i_timer_channel_checker (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq));
